// ===== logic/slgt_top.sv
// Speed command selection and speed loop gain tuning controller
// Operation
// - Zero-speed mode forces speed command to zero
// - Analog mode passes analog input as command
// - Mode field: 0 manual, 1 auto, 2 semi
// - Manual mode uses user gains, no tuning
// - Auto mode saves inertia ratio every 30 minutes
// - Auto gains from bandwidth setting and inertia
// - Leaving auto modes stores inertia, sets gains
// - Auto to manual overwrites position, P, I gains
// - Semi to manual also overwrites filter parameters
// - Semi stable: flag one, stop, store inertia
// - Every semi entry restarts inertia estimation
// - Semi out of range: flag zero, resume
// - Proportional gain 16-bit, 0..8191, reset 500
// - Integral gain 16-bit, 0..1023, reset 100
// - Feed-forward gain percent, 0..100, reset 0
// - Auto mode keeps retuning gains from load
`timescale 1ns/1ns
`default_nettype none
module slgt_top
    import slgt_pkg::*;
#(
    parameter longint SAVE_CYCLES = SAVE_INTERVAL_CYC
) (
    // Clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        srst_i,
    // Parameter access port
    input  wire logic        host_wr_i,
    input  wire logic        host_rd_i,
    input  wire logic [15:0] host_addr_i,
    input  wire logic [15:0] host_wdata_i,
    output logic      [15:0] host_rdata_o,
    // Speed command source
    input  wire logic        speed_select_low_i,
    input  wire logic        speed_select_high_i,
    input  wire logic [15:0] analog_speed_i,
    output logic      [15:0] speed_cmd_o,
    // Inertia estimator
    input  wire logic [15:0] inertia_est_i,
    input  wire logic        est_stable_i,
    input  wire logic        est_out_of_range_i,
    output logic             est_enable_o,
    output logic             est_restart_o,
    // Active loop gains
    output logic      [15:0] prop_gain_term_o,
    output logic      [15:0] integral_gain_term_o,
    output logic      [15:0] feedforward_gain_term_o,
    output logic      [15:0] position_gain_o,
    output logic      [15:0] resonance_lowpass_o,
    output logic      [15:0] disturbance_rejection_o
);

    // ****************************************
    // Helper functions
    // ****************************************

    // Saturate a wide value to a limit
    function automatic logic [15:0] sat(input logic [31:0] v, input logic [15:0] lim);
        sat = (v > {16'h0000, lim}) ? lim : v[15:0];
    endfunction

    // Gain scales with bandwidth times (1 + ratio/16)
    function automatic logic [31:0] scale(input logic [15:0] bw, input logic [15:0] ratio);
        logic [31:0] prod;
        prod  = {16'h0000, bw} * ({16'h0000, ratio} + 32'h0000_0010);
        scale = prod >> 4;
    endfunction

    // ****************************************
    // Registers
    // ****************************************
    slgt_gains_t user_gains_reg;
    slgt_aux_t   user_aux_reg;
    slgt_mode_t  mode_reg;
    logic [15:0] ratio_reg;
    logic [15:0] bw_reg;
    logic        stable_reg;
    logic [35:0] save_cnt_reg;
    logic [1:0]  sel_low_sync_reg;
    logic [1:0]  sel_high_sync_reg;
    logic [15:0] speed_cmd_reg;
    logic [15:0] rdata_reg;
    logic        restart_reg;
    logic        est_en_reg;
    slgt_gains_t act_gains_reg;
    slgt_aux_t   act_aux_reg;

    // ****************************************
    // Write decode, range checks on speed gains, mode and lowpass
    // ****************************************
    wire wr_kp    = host_wr_i && host_addr_i == SPEED_PROPORTIONAL_GAIN_OFS
                    && host_wdata_i <= KP_MAX;
    wire wr_ki    = host_wr_i && host_addr_i == SPEED_INTEGRAL_GAIN_OFS
                    && host_wdata_i <= KI_MAX;
    wire wr_kf    = host_wr_i && host_addr_i == SPEED_FEEDFORWARD_GAIN_OFS
                    && host_wdata_i <= KF_MAX;
    wire wr_mode  = host_wr_i && host_addr_i == TUNING_MODE_SELECT_OFS
                    && host_wdata_i <= MODE_MAX;
    wire wr_ratio = host_wr_i && host_addr_i == INERTIA_RATIO_OFS;
    wire wr_bw    = host_wr_i && host_addr_i == STIFFNESS_BANDWIDTH_OFS;
    wire wr_pos   = host_wr_i && host_addr_i == POSITION_GAIN_OFS;
    wire wr_lp    = host_wr_i && host_addr_i == RESONANCE_LOWPASS_OFS
                    && host_wdata_i <= LP_MAX;
    wire wr_dr    = host_wr_i && host_addr_i == DISTURBANCE_REJECTION_OFS;

    // Mode decode of the incoming value
    wire slgt_mode_t new_mode = (host_wdata_i[1:0] == 2'h1) ? SLGT_AUTO :
                                (host_wdata_i[1:0] == 2'h2) ? SLGT_SEMI : SLGT_MANUAL;
    wire to_manual  = wr_mode && new_mode == SLGT_MANUAL && mode_reg != SLGT_MANUAL;
    wire auto_to_m  = to_manual && mode_reg == SLGT_AUTO;
    wire semi_to_m  = to_manual && mode_reg == SLGT_SEMI;
    wire enter_semi = wr_mode && new_mode == SLGT_SEMI && mode_reg != SLGT_SEMI;

    // ****************************************
    // Tuned gain computation
    // ****************************************

    // Semi mode freezes on the stored ratio once stable
    wire [15:0] eff_inertia = (mode_reg == SLGT_SEMI && stable_reg) ? ratio_reg
                                                                   : inertia_est_i;
    wire [15:0] tuned_kp  = sat(scale(bw_reg, eff_inertia), KP_MAX);
    wire [15:0] tuned_ki  = sat({18'h00000, tuned_kp[15:2]}, KI_MAX);
    wire [15:0] tuned_pos = {1'b0, tuned_kp[15:1]};
    wire [15:0] tuned_lp  = sat({16'h0000, bw_reg}, LP_MAX);
    wire [15:0] tuned_dr  = {2'b00, tuned_kp[15:2]};

    // Gains used by the loop: all user values in manual mode, user kf in every mode
    wire slgt_gains_t act_gains_next =
        (mode_reg == SLGT_MANUAL) ? user_gains_reg :
        slgt_gains_t'{kp: tuned_kp, ki: tuned_ki, kf: user_gains_reg.kf};
    wire slgt_aux_t act_aux_next =
        (mode_reg == SLGT_MANUAL) ? user_aux_reg :
        (mode_reg == SLGT_AUTO)   ? slgt_aux_t'{position: tuned_pos,
                                                lowpass:  user_aux_reg.lowpass,
                                                disturb:  user_aux_reg.disturb} :
        slgt_aux_t'{position: tuned_pos, lowpass: tuned_lp, disturb: tuned_dr};

    // ****************************************
    // Periodic ratio save in auto mode
    // ****************************************
    wire save_tick = (mode_reg == SLGT_AUTO) && (save_cnt_reg == 36'(SAVE_CYCLES - 1));

    always_ff @(posedge core_clk_i) begin
        if (srst_i || mode_reg != SLGT_AUTO || save_tick) begin
            save_cnt_reg <= 36'h0_0000_0000;
        end else begin
            save_cnt_reg <= save_cnt_reg + 36'h0_0000_0001;
        end
    end

    // ****************************************
    // Semi mode stability tracking
    // ****************************************
    wire semi_lock = mode_reg == SLGT_SEMI && !stable_reg && est_stable_i && !enter_semi;
    wire semi_lost = mode_reg == SLGT_SEMI && stable_reg && est_out_of_range_i;

    // Stable flag; restart on entry clears it
    always_ff @(posedge core_clk_i) begin
        if (srst_i || enter_semi) begin
            stable_reg <= 1'b0;
        end else if (semi_lock) begin
            stable_reg <= 1'b1;
        end else if (semi_lost) begin
            stable_reg <= 1'b0;
        end
    end

    // Inertia ratio; hardware saves win over a host write
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            ratio_reg <= RATIO_RESET;
        end else if (to_manual || save_tick || semi_lock) begin
            ratio_reg <= (to_manual && mode_reg == SLGT_SEMI && stable_reg) ? ratio_reg
                                                                           : inertia_est_i;
        end else if (wr_ratio) begin
            ratio_reg <= host_wdata_i;
        end
    end

    // ****************************************
    // Mode and user parameters
    // ****************************************
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            mode_reg <= SLGT_MANUAL;
            bw_reg   <= BW_RESET;
        end else begin
            if (wr_mode) begin
                mode_reg <= new_mode;
            end
            if (wr_bw) begin
                bw_reg <= host_wdata_i;
            end
        end
    end

    // Speed loop gains; leaving auto modes copies tuned values in
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            user_gains_reg <= '{kp: KP_RESET, ki: KI_RESET, kf: KF_RESET};
        end else if (to_manual) begin
            user_gains_reg.kp <= tuned_kp;
            user_gains_reg.ki <= tuned_ki;
        end else begin
            if (wr_kp) user_gains_reg.kp <= host_wdata_i;
            if (wr_ki) user_gains_reg.ki <= host_wdata_i;
            if (wr_kf) user_gains_reg.kf <= host_wdata_i;
        end
    end

    // Position gain and filter parameters
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            user_aux_reg <= '{position: POS_RESET, lowpass: LP_RESET, disturb: DR_RESET};
        end else if (auto_to_m) begin
            user_aux_reg.position <= tuned_pos;
        end else if (semi_to_m) begin
            user_aux_reg <= '{position: tuned_pos, lowpass: tuned_lp, disturb: tuned_dr};
        end else begin
            if (wr_pos) user_aux_reg.position <= host_wdata_i;
            if (wr_lp)  user_aux_reg.lowpass  <= host_wdata_i;
            if (wr_dr)  user_aux_reg.disturb  <= host_wdata_i;
        end
    end

    // ****************************************
    // Estimator control and active gains
    // ****************************************
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            est_en_reg    <= 1'b0;
            restart_reg   <= 1'b0;
            act_gains_reg <= '{kp: KP_RESET, ki: KI_RESET, kf: KF_RESET};
            act_aux_reg   <= '{position: POS_RESET, lowpass: LP_RESET, disturb: DR_RESET};
        end else begin
            est_en_reg    <= mode_reg == SLGT_AUTO
                             || (mode_reg == SLGT_SEMI && !stable_reg);
            restart_reg   <= enter_semi;
            act_gains_reg <= act_gains_next;
            act_aux_reg   <= act_aux_next;
        end
    end

    // ****************************************
    // Speed command source
    // ****************************************

    // Select pins are asynchronous, two stages each
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            sel_low_sync_reg  <= 2'h0;
            sel_high_sync_reg <= 2'h0;
        end else begin
            sel_low_sync_reg  <= {sel_low_sync_reg[0], speed_select_low_i};
            sel_high_sync_reg <= {sel_high_sync_reg[0], speed_select_high_i};
        end
    end

    // Both selects open picks zero speed, otherwise analog
    wire zero_speed_mode = !sel_low_sync_reg[1] && !sel_high_sync_reg[1];
    wire [15:0] internal_cmd_one = zero_speed_mode ? 16'h0000 : analog_speed_i;

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            speed_cmd_reg <= 16'h0000;
        end else begin
            speed_cmd_reg <= internal_cmd_one;
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    logic [15:0] rdata_next;

    // Unmapped offsets read as zero
    always_comb begin
        if (host_addr_i == SPEED_PROPORTIONAL_GAIN_OFS) begin
            rdata_next = user_gains_reg.kp;
        end else if (host_addr_i == SPEED_INTEGRAL_GAIN_OFS) begin
            rdata_next = user_gains_reg.ki;
        end else if (host_addr_i == SPEED_FEEDFORWARD_GAIN_OFS) begin
            rdata_next = user_gains_reg.kf;
        end else if (host_addr_i == TUNING_MODE_SELECT_OFS) begin
            rdata_next = {14'h0000, mode_reg};
        end else if (host_addr_i == INERTIA_RATIO_OFS) begin
            rdata_next = ratio_reg;
        end else if (host_addr_i == STIFFNESS_BANDWIDTH_OFS) begin
            rdata_next = bw_reg;
        end else if (host_addr_i == INERTIA_STABLE_FLAG_OFS) begin
            rdata_next = {15'h0000, stable_reg};
        end else if (host_addr_i == POSITION_GAIN_OFS) begin
            rdata_next = user_aux_reg.position;
        end else if (host_addr_i == RESONANCE_LOWPASS_OFS) begin
            rdata_next = user_aux_reg.lowpass;
        end else if (host_addr_i == DISTURBANCE_REJECTION_OFS) begin
            rdata_next = user_aux_reg.disturb;
        end else begin
            rdata_next = 16'h0000;
        end
    end

    // Data held until the next read
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            rdata_reg <= 16'h0000;
        end else if (host_rd_i) begin
            rdata_reg <= rdata_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign host_rdata_o            = rdata_reg;
    assign speed_cmd_o             = speed_cmd_reg;
    assign est_enable_o            = est_en_reg;
    assign est_restart_o           = restart_reg;
    assign prop_gain_term_o        = act_gains_reg.kp;
    assign integral_gain_term_o    = act_gains_reg.ki;
    assign feedforward_gain_term_o = act_gains_reg.kf;
    assign position_gain_o         = act_aux_reg.position;
    assign resonance_lowpass_o     = act_aux_reg.lowpass;
    assign disturbance_rejection_o = act_aux_reg.disturb;

endmodule
`default_nettype wire

// ===== logic/slgt_pkg.sv
// Package of constants and types for the speed loop gain tuning block
package slgt_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [15:0] SPEED_PROPORTIONAL_GAIN_OFS = 16'h0208;
    localparam logic [15:0] SPEED_INTEGRAL_GAIN_OFS     = 16'h020c;
    localparam logic [15:0] SPEED_FEEDFORWARD_GAIN_OFS  = 16'h020e;
    localparam logic [15:0] TUNING_MODE_SELECT_OFS      = 16'h0240;
    localparam logic [15:0] INERTIA_RATIO_OFS           = 16'h0300;
    localparam logic [15:0] STIFFNESS_BANDWIDTH_OFS     = 16'h0302;
    localparam logic [15:0] INERTIA_STABLE_FLAG_OFS     = 16'h0304;
    localparam logic [15:0] POSITION_GAIN_OFS           = 16'h0306;
    localparam logic [15:0] RESONANCE_LOWPASS_OFS       = 16'h0308;
    localparam logic [15:0] DISTURBANCE_REJECTION_OFS   = 16'h030a;

    // ****************************************
    // Reset values and legal maxima
    // ****************************************
    localparam logic [15:0] KP_RESET      = 16'h01f4;
    localparam logic [15:0] KI_RESET      = 16'h0064;
    localparam logic [15:0] KF_RESET      = 16'h0000;
    localparam logic [15:0] MODE_RESET    = 16'h0000;
    localparam logic [15:0] RATIO_RESET   = 16'h000a;
    localparam logic [15:0] BW_RESET      = 16'h0064;
    localparam logic [15:0] POS_RESET     = 16'h0023;
    localparam logic [15:0] LP_RESET      = 16'h0000;
    localparam logic [15:0] DR_RESET      = 16'h0000;
    localparam logic [15:0] KP_MAX        = 16'h1fff;
    localparam logic [15:0] KI_MAX        = 16'h03ff;
    localparam logic [15:0] KF_MAX        = 16'h0064;
    localparam logic [15:0] MODE_MAX      = 16'h0002;
    localparam logic [15:0] LP_MAX        = 16'h03e8;

    // ****************************************
    // Timing
    // ****************************************
    localparam longint CLK_HZ           = 20000000;
    localparam longint SAVE_INTERVAL_MIN = 30;
    localparam longint SAVE_INTERVAL_CYC = SAVE_INTERVAL_MIN * 60 * CLK_HZ;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        SLGT_MANUAL,
        SLGT_AUTO,
        SLGT_SEMI
    } slgt_mode_t;

    typedef struct packed {
        logic [15:0] kp;
        logic [15:0] ki;
        logic [15:0] kf;
    } slgt_gains_t;

    typedef struct packed {
        logic [15:0] position;
        logic [15:0] lowpass;
        logic [15:0] disturb;
    } slgt_aux_t;

endpackage

// ===== bench/slgt_est_model.sv
// Inertia estimator model that settles after a run of enabled cycles
`timescale 1ns/1ns
`default_nettype none
module slgt_est_model (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic srst_i,
    // Estimator control from the block
    input  wire logic est_enable_i,
    input  wire logic est_restart_i,
    // Stable report to the block
    output logic      est_stable_o
);
    // ****************************************
    // Settling counter
    // ****************************************
    logic [3:0] settle_reg;
    // Cleared while stopped, so no stale lock survives a restart
    always_ff @(posedge clk_i) begin
        if (srst_i || est_restart_i || !est_enable_i) begin
            settle_reg <= 4'h0;
        end else if (settle_reg != 4'hf) begin
            settle_reg <= settle_reg + 4'h1;
        end
    end
    assign est_stable_o = (settle_reg >= 4'h8);
endmodule
`default_nettype wire

// ===== bench/slgt_checker.sv
// Port assertions for the speed loop gain tuning block
`timescale 1ns/1ns
`default_nettype none
module slgt_checker
    import slgt_pkg::*;
#(
    parameter longint SAVE_CYCLES = SAVE_INTERVAL_CYC
) (
    // Clock and reset
    input wire logic        core_clk_i,
    input wire logic        srst_i,
    // Parameter access port
    input wire logic        host_wr_i,
    input wire logic        host_rd_i,
    input wire logic [15:0] host_addr_i,
    input wire logic [15:0] host_wdata_i,
    input wire logic [15:0] host_rdata_o,
    // Speed command source
    input wire logic        speed_select_low_i,
    input wire logic        speed_select_high_i,
    input wire logic [15:0] analog_speed_i,
    input wire logic [15:0] speed_cmd_o,
    // Inertia estimator
    input wire logic [15:0] inertia_est_i,
    input wire logic        est_stable_i,
    input wire logic        est_out_of_range_i,
    input wire logic        est_enable_o,
    input wire logic        est_restart_o,
    // Active loop gains
    input wire logic [15:0] prop_gain_term_o,
    input wire logic [15:0] integral_gain_term_o,
    input wire logic [15:0] feedforward_gain_term_o,
    input wire logic [15:0] position_gain_o,
    input wire logic [15:0] resonance_lowpass_o,
    input wire logic [15:0] disturbance_rejection_o
);
    // ****************************************
    // Decode and assertions
    // ****************************************
    // Mode writes, the cause of every estimator restart and of stops without a stable report
    wire logic mode_wr = host_wr_i && (host_addr_i == TUNING_MODE_SELECT_OFS);
    wire logic semi_wr = mode_wr && (host_wdata_i == 16'h0002);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    sequence kp_write_s;
        host_wr_i && host_addr_i == SPEED_PROPORTIONAL_GAIN_OFS && host_wdata_i <= KP_MAX;
    endsequence
    sequence kp_read_s;
        host_rd_i && !host_wr_i && host_addr_i == SPEED_PROPORTIONAL_GAIN_OFS;
    endsequence
    zero_cmd_a: assert property (
        (!speed_select_low_i && !speed_select_high_i) [*4] |=> speed_cmd_o == 16'h0000)
        else $error("speed command not zero");
    analog_cmd_a: assert property (
        (speed_select_low_i || speed_select_high_i) [*4] |=> speed_cmd_o == $past(analog_speed_i))
        else $error("speed command not analog");
    reset_vals_a: assert property (disable iff (1'b0) srst_i |=>
        prop_gain_term_o == 16'h01f4 && integral_gain_term_o == 16'h0064
        && feedforward_gain_term_o == 16'h0000 && !est_enable_o) else $error("bad reset");
    rdata_hold_a: assert property (!host_rd_i |=> $stable(host_rdata_o))
        else $error("read data moved");
    kp_readback_a: assert property (
        kp_write_s ##1 !host_wr_i ##1 kp_read_s |=> host_rdata_o == $past(host_wdata_i, 3))
        else $error("legal gain write lost");
    restart_pulse_a: assert property (est_restart_o |=> !est_restart_o)
        else $error("restart longer than one cycle");
    restart_cause_a: assert property (
        est_restart_o |-> $past(semi_wr) || $past(semi_wr, 2)) else $error("stray restart");
    enable_drop_a: assert property ($fell(est_enable_o) |-> $past(est_stable_i)
        || $past(est_stable_i, 2) || $past(mode_wr) || $past(mode_wr, 2) || $past(mode_wr, 3))
        else $error("estimation stopped without cause");
endmodule
bind slgt_top slgt_checker #(.SAVE_CYCLES(SAVE_CYCLES)) i_checker (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .host_wr_i(host_wr_i), .host_rd_i(host_rd_i),
    .host_addr_i(host_addr_i), .host_wdata_i(host_wdata_i), .host_rdata_o(host_rdata_o),
    .speed_select_low_i(speed_select_low_i), .speed_select_high_i(speed_select_high_i),
    .analog_speed_i(analog_speed_i), .speed_cmd_o(speed_cmd_o), .inertia_est_i(inertia_est_i),
    .est_stable_i(est_stable_i), .est_out_of_range_i(est_out_of_range_i),
    .est_enable_o(est_enable_o), .est_restart_o(est_restart_o),
    .prop_gain_term_o(prop_gain_term_o), .integral_gain_term_o(integral_gain_term_o),
    .feedforward_gain_term_o(feedforward_gain_term_o), .position_gain_o(position_gain_o),
    .resonance_lowpass_o(resonance_lowpass_o),
    .disturbance_rejection_o(disturbance_rejection_o)
);
`default_nettype wire

// ===== bench/tb_slgt_top.sv
// Self-checking testbench for the speed loop gain tuning block
`timescale 1ns/1ns
`default_nettype none
module tb_slgt_top;
    import slgt_pkg::*;
    // ****************************************
    // Stimulus, instances and checks
    // ****************************************
    localparam longint      SAVE_N = 20;
    localparam logic [15:0] MODE_A = TUNING_MODE_SELECT_OFS;
    logic        clk     = 1'b0;
    logic        srst    = 1'b1;
    logic        wr      = 1'b0;
    logic        rd      = 1'b0;
    logic [15:0] addr    = 16'h0000;
    logic [15:0] wdata   = 16'h0000;
    logic        sel_lo  = 1'b0;
    logic        sel_hi  = 1'b0;
    logic [15:0] analog  = 16'h0000;
    logic [15:0] inertia = 16'h0010;
    logic        oor     = 1'b0;
    logic [15:0] rdata, cmd, kp, ki, kf, pos, lp, dr;
    logic        stable, en, restart;
    slgt_gains_t act_g;
    int          bad_count   = 0;
    int          check_count = 0;
    int          pulse_n     = 0;
    logic [15:0] ofs [3] = '{SPEED_PROPORTIONAL_GAIN_OFS, SPEED_INTEGRAL_GAIN_OFS,
                             SPEED_FEEDFORWARD_GAIN_OFS};
    logic [15:0] lim [3] = '{16'h1fff, 16'h03ff, 16'h0064};
    logic [15:0] rst [3] = '{16'h01f4, 16'h0064, 16'h0000};
    slgt_top #(.SAVE_CYCLES(SAVE_N)) i_dut (
        .core_clk_i(clk), .srst_i(srst), .host_wr_i(wr), .host_rd_i(rd),
        .host_addr_i(addr), .host_wdata_i(wdata), .host_rdata_o(rdata),
        .speed_select_low_i(sel_lo), .speed_select_high_i(sel_hi),
        .analog_speed_i(analog), .speed_cmd_o(cmd), .inertia_est_i(inertia),
        .est_stable_i(stable), .est_out_of_range_i(oor), .est_enable_o(en),
        .est_restart_o(restart), .prop_gain_term_o(kp), .integral_gain_term_o(ki),
        .feedforward_gain_term_o(kf), .position_gain_o(pos), .resonance_lowpass_o(lp),
        .disturbance_rejection_o(dr)
    );
    slgt_est_model i_est (
        .clk_i(clk), .srst_i(srst), .est_enable_i(en), .est_restart_i(restart),
        .est_stable_o(stable)
    );
    assign act_g = {kp, ki, kf};
    // Clock, and restart pulses counted where they are settled
    always #25 clk = ~clk;
    always @(negedge clk) if (restart === 1'b1) pulse_n++;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_g(input slgt_gains_t got, input slgt_gains_t exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: gains %h, expected %h", $time, got, exp);
        end
    endtask
    // Bus cycles leave one idle edge, so strobes never toggle twice at once
    task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
        @(negedge clk);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
        @(negedge clk);
        rd = 1'b1;
        addr = a;
        @(negedge clk);
        rd = 1'b0;
        chk(rdata, exp);
    endtask
    task automatic finish_test();
        $display("Checks %0d, errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Main sequence: user gains, command source, then the tuning modes
    initial begin
        repeat (20) @(posedge clk);
        @(negedge clk);
        srst = 1'b0;
        chk_g(act_g, '{16'h01f4, 16'h0064, 16'h0000});
        rd_chk(MODE_A, 16'h0000);
        for (int i = 0; i < 3; i++) begin
            rd_chk(ofs[i], rst[i]);
            wr_reg(ofs[i], lim[i] + 16'h0001);
            rd_chk(ofs[i], rst[i]);
            wr_reg(ofs[i], lim[i]);
            rd_chk(ofs[i], lim[i]);
        end
        chk_g(act_g, '{16'h1fff, 16'h03ff, 16'h0064});
        wr_reg(MODE_A, 16'h0003);
        rd_chk(MODE_A, 16'h0000);
        wr_reg(INERTIA_STABLE_FLAG_OFS, 16'h0001);
        rd_chk(INERTIA_STABLE_FLAG_OFS, 16'h0000);
        rd_chk(16'h0100, 16'h0000);
        chk({15'h0000, en}, 16'h0000);
        analog = 16'h1234;
        for (int s = 0; s < 4; s++) begin
            {sel_hi, sel_lo} = s[1:0];
            repeat (4) @(negedge clk);
            chk(cmd, (s == 0) ? 16'h0000 : 16'h1234);
        end
        analog = 16'h0abc;
        repeat (2) @(negedge clk);
        chk(cmd, 16'h0abc);
        // Continuous tuning from a low starting ratio
        wr_reg(INERTIA_RATIO_OFS, 16'h0005);
        wr_reg(MODE_A, 16'h0001);
        repeat (3) @(negedge clk);
        chk_g(act_g, '{16'h00c8, 16'h0032, 16'h0064});
        chk(pos, 16'h0064);
        repeat (SAVE_N + 5) @(negedge clk);
        rd_chk(INERTIA_RATIO_OFS, 16'h0010);
        inertia = 16'h0030;
        repeat (3) @(negedge clk);
        chk_g(act_g, '{16'h0190, 16'h0064, 16'h0064});
        wr_reg(MODE_A, 16'h0000);
        rd_chk(SPEED_PROPORTIONAL_GAIN_OFS, 16'h0190);
        rd_chk(SPEED_INTEGRAL_GAIN_OFS, 16'h0064);
        rd_chk(POSITION_GAIN_OFS, 16'h00c8);
        rd_chk(INERTIA_RATIO_OFS, 16'h0030);
        chk_g(act_g, '{16'h0190, 16'h0064, 16'h0064});
        // Semi tuning: restart, lock, unlock, hand back to manual
        inertia = 16'h0010;
        wr_reg(MODE_A, 16'h0002);
        repeat (2) @(negedge clk);
        chk(pulse_n[15:0], 16'h0001);
        chk({15'h0000, en}, 16'h0001);
        repeat (12) @(negedge clk);
        rd_chk(INERTIA_STABLE_FLAG_OFS, 16'h0001);
        rd_chk(INERTIA_RATIO_OFS, 16'h0010);
        chk({15'h0000, en}, 16'h0000);
        chk(lp, 16'h0064);
        chk(dr, 16'h0032);
        oor = 1'b1;
        repeat (2) @(negedge clk);
        rd_chk(INERTIA_STABLE_FLAG_OFS, 16'h0000);
        chk({15'h0000, en}, 16'h0001);
        oor = 1'b0;
        wr_reg(MODE_A, 16'h0000);
        rd_chk(RESONANCE_LOWPASS_OFS, 16'h0064);
        rd_chk(DISTURBANCE_REJECTION_OFS, 16'h0032);
        rd_chk(SPEED_PROPORTIONAL_GAIN_OFS, 16'h00c8);
        // Entry from auto, not only from manual, restarts estimation
        wr_reg(MODE_A, 16'h0001);
        wr_reg(MODE_A, 16'h0002);
        @(negedge clk);
        chk(pulse_n[15:0], 16'h0002);
        finish_test();
    end
    // Watchdog, far beyond the roughly 165 cycles the sequence needs
    initial begin
        #200000;
        bad_count++;
        finish_test();
    end
endmodule
`default_nettype wire
